// [bytecode_accel_pkg.sv]
// Constants shared by the bytecode accelerator configuration registers.
// Assumes coprocessor transfers are decoded in the core clock domain.
package bytecode_accel_pkg;

	// ----------------------------------------------------------------
	// Coprocessor coordinates of the two registers
	// ----------------------------------------------------------------
	localparam logic [2:0] CP_OPC1 = 3'h7;
	localparam logic [3:0] CP_CRN_CONTROL = 4'h2;
	localparam logic [3:0] CP_CRN_PARAMS = 4'h3;
	localparam logic [3:0] CP_CRM = 4'h0;
	localparam logic [2:0] CP_OPC2 = 3'h0;

	// ----------------------------------------------------------------
	// Main control register fields
	// ----------------------------------------------------------------
	localparam int CTRL_INDEX_WIDTH_BIT = 27;
	localparam int CTRL_STATIC_PTR_BIT = 26;
	localparam int CTRL_ENABLE_BIT = 0;
	localparam logic CTRL_INDEX_WIDTH_RESET = 1'b0;
	localparam logic CTRL_STATIC_PTR_RESET = 1'b0;
	localparam logic CTRL_ENABLE_RESET = 1'b0;

	// ----------------------------------------------------------------
	// Layout parameters register fields
	// ----------------------------------------------------------------
	localparam int PARAMS_W = 22;
	localparam int BOUNDS_LSB = 17;
	localparam int BOUNDS_W = 5;
	localparam int DESC_SIGN_BIT = 16;
	localparam int DESC_MAG_LSB = 12;
	localparam int OFF_W = 4;
	localparam int ARRAY_REF_LSB = 8;
	localparam int STATIC_LSB = 4;
	localparam int FIELD_LSB = 0;
	localparam logic [PARAMS_W-1:0] PARAMS_RESET = 22'h000000;

	// ----------------------------------------------------------------
	// Quick field index widths, in bits
	// ----------------------------------------------------------------
	localparam logic [4:0] QUICK_INDEX_NARROW = 5'h08;
	localparam logic [4:0] QUICK_INDEX_WIDE = 5'h10;

endpackage

// [debug_coproc_if.sv]
// Decoded coprocessor access carried between the register bank and its decoder.
// Assumes one access at most per cycle, driven by the register bank.
`timescale 1ns/1ps
`default_nettype none
interface debug_coproc_if;
	logic access_valid;
	logic [2:0] opc1;
	logic [3:0] crn;
	logic [3:0] crm;
	logic [2:0] opc2;
	logic privileged;
	logic sel_control;
	logic sel_params;
	logic refused;

	modport decoder (
		input access_valid, opc1, crn, crm, opc2, privileged,
		output sel_control, sel_params, refused
	);
	modport bank (
		output access_valid, opc1, crn, crm, opc2, privileged,
		input sel_control, sel_params, refused
	);
endinterface
`default_nettype wire

// [debug_coproc_decode.sv]
// Decodes a coprocessor transfer into register selects and a refusal.
// Assumes the access fields are stable while access_valid is high.
`timescale 1ns/1ps
`default_nettype none
module debug_coproc_decode (
	debug_coproc_if.decoder acc
);

	// ----------------------------------------------------------------
	// Address match
	// ----------------------------------------------------------------
	function automatic logic coord_hit(input logic [3:0] crn_want);
		coord_hit = (acc.opc1 == bytecode_accel_pkg::CP_OPC1)
			&& (acc.crn == crn_want)
			&& (acc.crm == bytecode_accel_pkg::CP_CRM)
			&& (acc.opc2 == bytecode_accel_pkg::CP_OPC2);
	endfunction

	logic hit_control;
	logic hit_params;

	always_comb begin
		hit_control = coord_hit(bytecode_accel_pkg::CP_CRN_CONTROL);
		hit_params = coord_hit(bytecode_accel_pkg::CP_CRN_PARAMS);
	end

	// ----------------------------------------------------------------
	// Privilege gate
	// ----------------------------------------------------------------
	// Unprivileged or unmapped transfers select nothing and are refused
	always_comb begin
		acc.sel_control = acc.access_valid && acc.privileged && hit_control;
		acc.sel_params = acc.access_valid && acc.privileged && hit_params;
		acc.refused = acc.access_valid && !(acc.sel_control || acc.sel_params);
	end

endmodule // debug_coproc_decode
`default_nettype wire

// [bytecode_accel_config_regs.sv]
// Configuration register bank of the bytecode execution hardware.
// Assumes coprocessor transfers and instruction events arrive synchronous to core_clk_i.
//
// Summary of operation
// - Control bit 27 selects 8-bit (0) or 16-bit (1) quick field indices.
// - Control bit 26 selects static references as handles (0) or pointers (1).
// - Enable clear: bytecode branch behaves exactly like branch-and-exchange.
// - Enable clear: setting status bytecode flag raises disabled-hardware exception.
// - Enable set: bytecode branch enters bytecode execution state.
// - Enable set: writing status bytecode flag enters bytecode execution state.
// - Control register reached by coprocessor transfer opcode1 7, c2, c0, opcode2 0.
// - Parameters register accessible only from privileged modes.
// - Parameter bits 21:17 give element count bit position in descriptor word.
// - Parameter bits 16:12 are sign-magnitude word offset to array descriptor.
// - Bit 16 is descriptor offset sign, zero positive, one negative.
// - Bits 15:12 are unsigned descriptor offset magnitude in words.
// - Bits 11:8 give word offset to array data or data pointer.
// - Bits 7:4 give word offset to static value or its pointer.
// - Bits 3:0 give word offset of field from object data block.
// - Parameters register reached by transfer opcode1 7, c3, c0, opcode2 0.
// - Control register accessible only from privileged modes.
`timescale 1ns/1ps
`default_nettype none
module bytecode_accel_config_regs #(
	parameter int DATA_W = 32
) (
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic cp_valid_i,
	input wire logic cp_write_i,
	input wire logic [2:0] cp_opc1_i,
	input wire logic [3:0] cp_crn_i,
	input wire logic [3:0] cp_crm_i,
	input wire logic [2:0] cp_opc2_i,
	input wire logic cp_privileged_i,
	input wire logic [DATA_W-1:0] cp_wdata_i,
	output logic cp_done_o,
	output logic cp_undef_o,
	output logic [DATA_W-1:0] cp_rdata_o,
	input wire logic branch_to_bytecode_i,
	input wire logic psw_bytecode_set_i,
	output logic enter_bytecode_o,
	output logic branch_exchange_o,
	output logic disabled_exception_o,
	output logic engine_enable_o,
	output logic [4:0] quick_field_index_width_o,
	output logic static_ref_as_pointer_o,
	output logic [bytecode_accel_pkg::BOUNDS_W-1:0] bounds_shift_o,
	output logic [bytecode_accel_pkg::OFF_W+1:0] array_descriptor_offset_o,
	output logic [bytecode_accel_pkg::OFF_W-1:0] array_ref_offset_o,
	output logic [bytecode_accel_pkg::OFF_W-1:0] static_offset_o,
	output logic [bytecode_accel_pkg::OFF_W-1:0] object_field_offset_o
);

	localparam int PW = bytecode_accel_pkg::PARAMS_W;
	localparam int OW = bytecode_accel_pkg::OFF_W;

	// ----------------------------------------------------------------
	// Access decode
	// ----------------------------------------------------------------
	debug_coproc_if acc ();

	assign acc.access_valid = cp_valid_i;
	assign acc.opc1 = cp_opc1_i;
	assign acc.crn = cp_crn_i;
	assign acc.crm = cp_crm_i;
	assign acc.opc2 = cp_opc2_i;
	assign acc.privileged = cp_privileged_i;

	debug_coproc_decode decode_u (
		.acc(acc)
	);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Sign-magnitude descriptor offset turned into two's complement words
	function automatic logic [OW+1:0] sign_mag_to_twos(
		input logic sign,
		input logic [OW-1:0] mag
	);
		logic [OW+1:0] wide;
		wide = {2'b00, mag};
		if (sign) begin
			sign_mag_to_twos = (~wide) + {{(OW+1){1'b0}}, 1'b1};
		end else begin
			sign_mag_to_twos = wide;
		end
	endfunction

	// Pulls a field of the offset width out of the parameters word
	function automatic logic [OW-1:0] offset_field(
		input logic [PW-1:0] word,
		input int lsb
	);
		offset_field = word[lsb +: OW];
	endfunction

	// ----------------------------------------------------------------
	// Main control register
	// ----------------------------------------------------------------
	logic index_wide_reg;
	logic index_wide_next;
	logic static_ptr_reg;
	logic static_ptr_next;
	logic enable_reg;
	logic enable_next;

	// Only the defined bits are stored, so reserved writes cannot leak
	always_comb begin
		index_wide_next = index_wide_reg;
		static_ptr_next = static_ptr_reg;
		enable_next = enable_reg;
		if (acc.sel_control && cp_write_i) begin
			index_wide_next = cp_wdata_i[bytecode_accel_pkg::CTRL_INDEX_WIDTH_BIT];
			static_ptr_next = cp_wdata_i[bytecode_accel_pkg::CTRL_STATIC_PTR_BIT];
			enable_next = cp_wdata_i[bytecode_accel_pkg::CTRL_ENABLE_BIT];
		end
	end

	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			index_wide_reg <= bytecode_accel_pkg::CTRL_INDEX_WIDTH_RESET;
			static_ptr_reg <= bytecode_accel_pkg::CTRL_STATIC_PTR_RESET;
			enable_reg <= bytecode_accel_pkg::CTRL_ENABLE_RESET;
		end else begin
			index_wide_reg <= index_wide_next;
			static_ptr_reg <= static_ptr_next;
			enable_reg <= enable_next;
		end
	end

	// ----------------------------------------------------------------
	// Layout parameters register
	// ----------------------------------------------------------------
	logic [PW-1:0] params_reg;
	logic [PW-1:0] params_next;

	// Bits above the bounds shift field are dropped on write
	always_comb begin
		params_next = params_reg;
		if (acc.sel_params && cp_write_i) begin
			params_next = cp_wdata_i[PW-1:0];
		end
	end

	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			params_reg <= bytecode_accel_pkg::PARAMS_RESET;
		end else begin
			params_reg <= params_next;
		end
	end

	// ----------------------------------------------------------------
	// Read and answer path
	// ----------------------------------------------------------------
	logic done_reg;
	logic done_next;
	logic undef_reg;
	logic undef_next;
	logic [DATA_W-1:0] rdata_reg;
	logic [DATA_W-1:0] rdata_next;

	// Read data is the stored value on accepted reads and zero on write or refused accesses
	always_comb begin
		done_next = cp_valid_i;
		undef_next = acc.refused;
		rdata_next = '0;
		if (acc.sel_control && !cp_write_i) begin
			rdata_next[bytecode_accel_pkg::CTRL_INDEX_WIDTH_BIT] = index_wide_reg;
			rdata_next[bytecode_accel_pkg::CTRL_STATIC_PTR_BIT] = static_ptr_reg;
			rdata_next[bytecode_accel_pkg::CTRL_ENABLE_BIT] = enable_reg;
		end else if (acc.sel_params && !cp_write_i) begin
			rdata_next[PW-1:0] = params_reg;
		end
	end

	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			done_reg <= 1'b0;
			undef_reg <= 1'b0;
			rdata_reg <= '0;
		end else begin
			done_reg <= done_next;
			undef_reg <= undef_next;
			rdata_reg <= rdata_next;
		end
	end

	assign cp_done_o = done_reg;
	assign cp_undef_o = undef_reg;
	assign cp_rdata_o = rdata_reg;

	// ----------------------------------------------------------------
	// Bytecode state entry
	// ----------------------------------------------------------------
	logic enter_reg;
	logic enter_next;
	logic plain_branch_reg;
	logic plain_branch_next;
	logic disabled_reg;
	logic disabled_next;

	// Decisions use the enable already stored; a write in the same cycle
	// affects only the following instructions.
	always_comb begin
		enter_next = 1'b0;
		plain_branch_next = 1'b0;
		disabled_next = 1'b0;
		if (enable_reg) begin
			enter_next = branch_to_bytecode_i
				|| psw_bytecode_set_i;
		end else begin
			plain_branch_next = branch_to_bytecode_i;
			disabled_next = psw_bytecode_set_i;
		end
	end

	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			enter_reg <= 1'b0;
			plain_branch_reg <= 1'b0;
			disabled_reg <= 1'b0;
		end else begin
			enter_reg <= enter_next;
			plain_branch_reg <= plain_branch_next;
			disabled_reg <= disabled_next;
		end
	end

	assign enter_bytecode_o = enter_reg;
	assign branch_exchange_o = plain_branch_reg;
	assign disabled_exception_o = disabled_reg;

	// ----------------------------------------------------------------
	// Configuration outputs
	// ----------------------------------------------------------------
	assign engine_enable_o = enable_reg;
	assign static_ref_as_pointer_o = static_ptr_reg;

	always_comb begin
		if (index_wide_reg) begin
			quick_field_index_width_o = bytecode_accel_pkg::QUICK_INDEX_WIDE;
		end else begin
			quick_field_index_width_o = bytecode_accel_pkg::QUICK_INDEX_NARROW;
		end
	end

	assign bounds_shift_o =
		params_reg[bytecode_accel_pkg::BOUNDS_LSB +: bytecode_accel_pkg::BOUNDS_W];

	// Signed word offset; the magnitude range is symmetric, so no overflow
	assign array_descriptor_offset_o = sign_mag_to_twos(
		params_reg[bytecode_accel_pkg::DESC_SIGN_BIT],
		offset_field(params_reg, bytecode_accel_pkg::DESC_MAG_LSB)
	);

	assign array_ref_offset_o =
		offset_field(params_reg, bytecode_accel_pkg::ARRAY_REF_LSB);
	assign static_offset_o =
		offset_field(params_reg, bytecode_accel_pkg::STATIC_LSB);
	assign object_field_offset_o =
		offset_field(params_reg, bytecode_accel_pkg::FIELD_LSB);

endmodule // bytecode_accel_config_regs
`default_nettype wire

// [bytecode_accel_config_regs_properties.sv]
// Concurrent checks on the ports of the bytecode accelerator register bank.
// Assumes one core clock and an active-high asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module bytecode_accel_config_regs_checker #(
	parameter int DATA_W = 32
) (
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic cp_valid_i,
	input wire logic cp_write_i,
	input wire logic [2:0] cp_opc1_i,
	input wire logic [3:0] cp_crn_i,
	input wire logic [3:0] cp_crm_i,
	input wire logic [2:0] cp_opc2_i,
	input wire logic cp_privileged_i,
	input wire logic [DATA_W-1:0] cp_wdata_i,
	input wire logic cp_done_o,
	input wire logic cp_undef_o,
	input wire logic [DATA_W-1:0] cp_rdata_o,
	input wire logic branch_to_bytecode_i,
	input wire logic psw_bytecode_set_i,
	input wire logic enter_bytecode_o,
	input wire logic branch_exchange_o,
	input wire logic disabled_exception_o,
	input wire logic engine_enable_o,
	input wire logic [4:0] quick_field_index_width_o,
	input wire logic static_ref_as_pointer_o,
	input wire logic [4:0] bounds_shift_o,
	input wire logic [5:0] array_descriptor_offset_o,
	input wire logic [3:0] array_ref_offset_o,
	input wire logic [3:0] static_offset_o,
	input wire logic [3:0] object_field_offset_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (reset_i);
	logic wr_ok;
	// Privileged write at the right coordinates, register still to be chosen
	assign wr_ok = cp_valid_i && cp_write_i && cp_privileged_i && cp_opc1_i == 3'h7
		&& cp_crm_i == 4'h0 && cp_opc2_i == 3'h0;
	AST_ANSWER: assert property (cp_valid_i |=> cp_done_o)
		else $error("transfer not answered");
	AST_UNPRIV: assert property (cp_valid_i && !cp_privileged_i |=>
		cp_undef_o && cp_rdata_o == '0)
		else $error("unprivileged transfer not refused");
	AST_CTL: assert property (wr_ok && cp_crn_i == 4'h2 |=>
		engine_enable_o == $past(cp_wdata_i[0])
		&& static_ref_as_pointer_o == $past(cp_wdata_i[26]))
		else $error("control write not stored");
	AST_WIDTH: assert property (wr_ok && cp_crn_i == 4'h2 |=>
		quick_field_index_width_o == ($past(cp_wdata_i[27]) ? 5'h10 : 5'h08))
		else $error("index width wrong");
	AST_PAR: assert property (wr_ok && cp_crn_i == 4'h3 |=>
		{bounds_shift_o, array_ref_offset_o, static_offset_o, object_field_offset_o}
		== {$past(cp_wdata_i[21:17]), $past(cp_wdata_i[11:0])})
		else $error("layout fields wrong");
	AST_DESC: assert property (wr_ok && cp_crn_i == 4'h3 |=>
		array_descriptor_offset_o == ($past(cp_wdata_i[16])
		? 6'h00 - {2'h0, $past(cp_wdata_i[15:12])} : {2'h0, $past(cp_wdata_i[15:12])}))
		else $error("descriptor offset wrong");
	AST_PLAIN_OFF: assert property (branch_to_bytecode_i && !engine_enable_o |=>
		branch_exchange_o && !enter_bytecode_o)
		else $error("disabled branch not plain");
	AST_DIS_OFF: assert property (psw_bytecode_set_i && !engine_enable_o |=>
		disabled_exception_o && !enter_bytecode_o)
		else $error("disabled flag set not trapped");
	AST_ON: assert property (engine_enable_o
		&& (branch_to_bytecode_i || psw_bytecode_set_i) |=>
		enter_bytecode_o && !branch_exchange_o && !disabled_exception_o)
		else $error("enabled entry missed");
	cover property (wr_ok && cp_crn_i == 4'h3);
	cover property (cp_valid_i && !cp_privileged_i);
	cover property (branch_to_bytecode_i && engine_enable_o);
endmodule // bytecode_accel_config_regs_checker
bind bytecode_accel_config_regs bytecode_accel_config_regs_checker #(.DATA_W(DATA_W)) chk_u (
	.core_clk_i, .reset_i, .cp_valid_i, .cp_write_i, .cp_opc1_i, .cp_crn_i, .cp_crm_i, .cp_opc2_i,
	.cp_privileged_i, .cp_wdata_i, .cp_done_o, .cp_undef_o, .cp_rdata_o, .branch_to_bytecode_i,
	.psw_bytecode_set_i, .enter_bytecode_o, .branch_exchange_o, .disabled_exception_o,
	.engine_enable_o, .quick_field_index_width_o, .static_ref_as_pointer_o, .bounds_shift_o,
	.array_descriptor_offset_o, .array_ref_offset_o, .static_offset_o, .object_field_offset_o);
`default_nettype wire

// [tb_bytecode_accel_config_regs.sv]
// Self-checking bench for the bytecode accelerator register bank.
// Assumes the checker is bound in; drives all ports directly.
`timescale 1ns/1ps
`default_nettype none
module tb_bytecode_accel_config_regs;
	// Coordinates {opc1, crn, crm, opc2} of the two registers
	localparam logic [13:0] AT_CTL = 14'h3900;
	localparam logic [13:0] AT_PAR = 14'h3980;
	logic core_clk_i, reset_i, cp_valid_i, cp_write_i, cp_privileged_i, cp_done_o, cp_undef_o;
	logic branch_to_bytecode_i, psw_bytecode_set_i, enter_bytecode_o, branch_exchange_o;
	logic disabled_exception_o, engine_enable_o, static_ref_as_pointer_o, und;
	logic [2:0] cp_opc1_i, cp_opc2_i;
	logic [3:0] cp_crn_i, cp_crm_i, array_ref_offset_o, static_offset_o, object_field_offset_o;
	logic [31:0] cp_wdata_i, cp_rdata_o, rd;
	logic [4:0] quick_field_index_width_o, bounds_shift_o;
	logic [5:0] array_descriptor_offset_o;
	int errors, n_compared;
	bytecode_accel_config_regs #(.DATA_W(32)) dut_u (.core_clk_i, .reset_i, .cp_valid_i,
		.cp_write_i, .cp_opc1_i, .cp_crn_i, .cp_crm_i, .cp_opc2_i, .cp_privileged_i, .cp_wdata_i,
		.cp_done_o, .cp_undef_o, .cp_rdata_o, .branch_to_bytecode_i, .psw_bytecode_set_i,
		.enter_bytecode_o, .branch_exchange_o, .disabled_exception_o, .engine_enable_o,
		.quick_field_index_width_o, .static_ref_as_pointer_o, .bounds_shift_o,
		.array_descriptor_offset_o, .array_ref_offset_o, .static_offset_o, .object_field_offset_o);
	always #2.5 core_clk_i = ~core_clk_i;
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// One transfer; answer is sampled just after the edge that raises done
	task automatic cp(input logic wr, input logic [13:0] at, input logic priv, input logic [31:0] wd);
		@(posedge core_clk_i);
		cp_valid_i <= 1'b1;
		cp_write_i <= wr;
		{cp_opc1_i, cp_crn_i, cp_crm_i, cp_opc2_i} <= at;
		cp_privileged_i <= priv;
		cp_wdata_i <= wd;
		@(posedge core_clk_i);
		cp_valid_i <= 1'b0;
		#1;
		rd = cp_rdata_o;
		und = cp_undef_o;
		check("done", 32'(cp_done_o), 32'h1);
	endtask
	task automatic ev(input logic br, input logic ps, input logic [2:0] exp);
		logic [2:0] seen;
		@(posedge core_clk_i);
		branch_to_bytecode_i <= br;
		psw_bytecode_set_i <= ps;
		@(posedge core_clk_i);
		branch_to_bytecode_i <= 1'b0;
		psw_bytecode_set_i <= 1'b0;
		#1;
		seen = {enter_bytecode_o, branch_exchange_o, disabled_exception_o};
		check("event", 32'(seen), 32'(exp));
	endtask
	task automatic t_control;
		check("width", 32'(quick_field_index_width_o), 32'h8);
		ev(1'b1, 1'b1, 3'b011);
		cp(1'b1, AT_CTL, 1'b1, 32'hfc000001);
		check("undef", 32'(und), 32'h0);
		check("enable", 32'(engine_enable_o), 32'h1);
		check("width", 32'(quick_field_index_width_o), 32'h10);
		check("ptr", 32'(static_ref_as_pointer_o), 32'h1);
		cp(1'b0, AT_CTL, 1'b1, 32'h0);
		check("ctl", rd, 32'h0c000001);
		ev(1'b1, 1'b0, 3'b100);
		ev(1'b0, 1'b1, 3'b100);
		ev(1'b1, 1'b1, 3'b100);
		cp(1'b1, AT_CTL, 1'b1, 32'h0);
		check("wrdata", rd, 32'h0);
		check("enable", 32'(engine_enable_o), 32'h0);
		check("ptr", 32'(static_ref_as_pointer_o), 32'h0);
		ev(1'b1, 1'b0, 3'b010);
		ev(1'b0, 1'b1, 3'b001);
	endtask
	task automatic t_params;
		cp(1'b1, AT_PAR, 1'b1, 32'hffeb35a7);
		check("bounds", 32'(bounds_shift_o), 32'h15);
		check("desc", 32'(array_descriptor_offset_o), 32'h3d);
		check("array ref", 32'(array_ref_offset_o), 32'h5);
		check("static", 32'(static_offset_o), 32'ha);
		check("field", 32'(object_field_offset_o), 32'h7);
		cp(1'b0, AT_PAR, 1'b1, 32'h0);
		check("par", rd, 32'h002b35a7);
		cp(1'b1, AT_PAR, 1'b1, 32'h0000f000);
		check("desc", 32'(array_descriptor_offset_o), 32'h0f);
	endtask
	// Wrong coordinates and unprivileged access must leave both registers alone
	task automatic t_refuse;
		logic [13:0] bad [5] = '{14'h3100, 14'h3908, 14'h3901, 14'h3c00, 14'h3880};
		foreach (bad[i]) begin
			cp(1'b1, bad[i], 1'b1, 32'hffffffff);
			check("undef", 32'(und), 32'h1);
		end
		cp(1'b1, AT_CTL, 1'b0, 32'h1);
		check("undef", 32'(und), 32'h1);
		cp(1'b1, AT_PAR, 1'b0, 32'h1);
		check("undef", 32'(und), 32'h1);
		cp(1'b0, AT_PAR, 1'b0, 32'h0);
		check("rdata", rd, 32'h0);
		cp(1'b0, AT_PAR, 1'b1, 32'h0);
		check("par", rd, 32'h0000f000);
		cp(1'b0, AT_CTL, 1'b1, 32'h0);
		check("ctl", rd, 32'h0);
	endtask
	task automatic complete_run;
		$display("errors %0d compared %0d", errors, n_compared);
		if (errors == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		{core_clk_i, cp_valid_i, cp_write_i, cp_privileged_i} = '0;
		{branch_to_bytecode_i, psw_bytecode_set_i, cp_opc1_i, cp_opc2_i, cp_crn_i, cp_crm_i} = '0;
		cp_wdata_i = '0;
		reset_i = 1'b1;
		repeat (5) @(posedge core_clk_i);
		reset_i <= 1'b0;
		t_control();
		t_params();
		t_refuse();
		complete_run();
	end
	// Whole sequence needs about 50 cycles
	initial begin
		repeat (2000) @(posedge core_clk_i);
		errors++;
		complete_run();
	end
endmodule // tb_bytecode_accel_config_regs
`default_nettype wire
